// ==== hw/hic_defines.svh ====
// Constants for the hub interrupt and bypass control block
`ifndef HIC_DEFINES_SVH
`define HIC_DEFINES_SVH

// Bypass select level after reset: negated high, hub operation
`define HIC_BYPASS_N_RST 1'b1
// Interrupt meaning select encodings
`define HIC_IRQ_SEL_GENERAL 1'b0
`define HIC_IRQ_SEL_SUSPEND 1'b1
// Open-drain enable: low drives the pin, high releases it
`define HIC_OE_N_DRIVE 1'b0
`define HIC_OE_N_RELEASE 1'b1
// Level driven onto the open-drain pin while enabled
`define HIC_PIN_LOW 1'b0

`endif

// ==== hw/hic_pkg.sv ====
// Types for the hub interrupt and bypass control block
package hic_pkg;

    // Operating mode of downstream port 3
    typedef enum logic {
        HIC_MODE_HUB,
        HIC_MODE_BYPASS
    } hic_mode_t;

    // State of the three-stage pin synchroniser
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } hic_sync_state_t;

    // State of the control top
    typedef struct packed {
        hic_mode_t mode;
        logic irq_pending;
        logic port3_hub_en;
        logic switch_en;
        logic port12_hiz;
        logic core_low_power;
        logic swap_eff;
        logic int_out;
        logic int_oe_n;
    } hic_top_state_t;

endpackage : hic_pkg

// ==== hw/hic_sync3.sv ====
// Three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/100ps
`include "hic_defines.svh"
module hic_sync3
    import hic_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    hic_sync_if.sync sif
);

    hic_sync_state_t st_reg;
    hic_sync_state_t st_next;

    // Shift chain; level moves only when stages two and three agree
    always_comb begin
        st_next = st_reg;
        st_next.s1 = sif.pin_raw;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (st_reg.s2 == st_reg.s3) begin
            st_next.level = st_reg.s3;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{s1: `HIC_BYPASS_N_RST, s2: `HIC_BYPASS_N_RST,
                        s3: `HIC_BYPASS_N_RST,
                        level: `HIC_BYPASS_N_RST};
        end else begin
            st_reg <= st_next;
        end
    end

    assign sif.level = st_reg.level;

endmodule : hic_sync3

// ==== hw/hic_sync_if.sv ====
// Interface between the bypass pin synchroniser and the control top
`timescale 1ns/100ps
interface hic_sync_if;
    logic pin_raw;
    logic level;

    modport sync (input pin_raw, output level);
    modport user (output pin_raw, input level);
endinterface : hic_sync_if

// ==== hw/hic_top.sv ====
// Pin-level bypass select and interrupt output control of the hub
`timescale 1ns/100ps
`include "hic_defines.svh"

// Summary of operation
// - Bypass high: port 3 is normal hub port
// - Port 3 has no disable strap
// - Bypass low: port 3 switched to upstream
// - Polarity swap ignored during bypass
// - Select bit picks general or suspend meaning
// - General mode: enabled status update asserts low
// - Host status update releases general interrupt
// - Suspend mode: low when unconfigured or suspended
// - Suspend mode: high when configured and active
// - Bypass: ports 1,2 high-Z, core low power
module hic_top
    import hic_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bypass_n_pin,
    input wire logic irq_suspend_select,
    input wire logic line_polarity_swap,
    input wire logic status_update,
    input wire logic irq_status_clear,
    input wire logic hub_configured,
    input wire logic hub_suspended,
    input wire logic int_pin_in,
    output logic int_pin_out,
    output logic int_pin_oe_n,
    output logic port3_hub_en,
    output logic switch_en,
    output logic port12_hiz,
    output logic core_low_power,
    output logic swap_eff
);

    hic_sync_if sif ();
    hic_top_state_t st_reg;
    hic_top_state_t st_next;
    logic suspend_idle;

    // Bypass select pin crosses into the clock domain here
    assign sif.pin_raw = bypass_n_pin;

    hic_sync3 u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .sif(sif)
    );

    // Hub is unconfigured, or configured but suspended
    assign suspend_idle = !hub_configured || hub_suspended;

    // Next state: mode, sticky interrupt and registered pin outputs
    always_comb begin
        st_next = st_reg;
        // Mode follows the filtered select; no strap is ever sampled
        if (sif.level) begin
            st_next.mode = HIC_MODE_HUB;
        end else begin
            st_next.mode = HIC_MODE_BYPASS;
        end
        // Sticky event; a set in the clearing cycle wins
        st_next.irq_pending = (st_reg.irq_pending && !irq_status_clear)
                              || status_update;
        st_next.port3_hub_en = (st_next.mode == HIC_MODE_HUB);
        st_next.switch_en = (st_next.mode == HIC_MODE_BYPASS);
        st_next.port12_hiz = (st_next.mode == HIC_MODE_BYPASS);
        st_next.core_low_power =
            (st_next.mode == HIC_MODE_BYPASS);
        // Swap only applies to the hub data path
        st_next.swap_eff = line_polarity_swap
                           && (st_next.mode == HIC_MODE_HUB);
        st_next.int_out = `HIC_PIN_LOW;
        // Interrupt pin meaning chosen by the select bit
        if (irq_suspend_select == `HIC_IRQ_SEL_GENERAL) begin
            st_next.int_oe_n = st_next.irq_pending ?
                `HIC_OE_N_DRIVE : `HIC_OE_N_RELEASE;
        end else begin
            st_next.int_oe_n = suspend_idle ?
                `HIC_OE_N_DRIVE : `HIC_OE_N_RELEASE;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{mode: HIC_MODE_HUB, irq_pending: 1'b0,
                        port3_hub_en: 1'b1, switch_en: 1'b0,
                        port12_hiz: 1'b0, core_low_power: 1'b0,
                        swap_eff: 1'b0, int_out: `HIC_PIN_LOW,
                        int_oe_n: `HIC_OE_N_RELEASE};
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign int_pin_out = st_reg.int_out;
    assign int_pin_oe_n = st_reg.int_oe_n;
    assign port3_hub_en = st_reg.port3_hub_en;
    assign switch_en = st_reg.switch_en;
    assign port12_hiz = st_reg.port12_hiz;
    assign core_low_power = st_reg.core_low_power;
    assign swap_eff = st_reg.swap_eff;

    // Checks on the control outputs
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_port3_hub_mode: assert property (
        sif.level |=> (port3_hub_en && !switch_en))
        else $error("port 3 not a hub port with select high");

    a_no_port3_strap: assert property (
        (sif.level && $past(sif.level)) |=> port3_hub_en)
        else $error("port 3 disabled outside bypass");

    a_bypass_switch_on: assert property (
        !sif.level |=> (switch_en && !port3_hub_en))
        else $error("bypass switch not closed with select low");

    a_swap_ignored: assert property (
        !sif.level |=> !swap_eff)
        else $error("polarity swap active in bypass");

    a_swap_follows: assert property (
        sif.level |=> (swap_eff == $past(line_polarity_swap)))
        else $error("polarity swap not applied in hub mode");

    a_bypass_low_power: assert property (
        !sif.level |=> (port12_hiz && core_low_power))
        else $error("ports 1,2 or core not reduced in bypass");

    a_general_assert: assert property (
        (!irq_suspend_select && status_update)
        |=> (int_pin_oe_n == `HIC_OE_N_DRIVE && int_pin_out == 1'b0))
        else $error("general interrupt not asserted on update");

    a_general_release: assert property (
        (!irq_suspend_select && irq_status_clear && !status_update)
        |=> int_pin_oe_n == `HIC_OE_N_RELEASE)
        else $error("general interrupt not released on clear");

    a_general_hold: assert property (
        (status_update ##1 (!irq_status_clear && !status_update)[*3])
        |-> st_reg.irq_pending)
        else $error("general interrupt self-cleared");

    a_set_wins_clear: assert property (
        (status_update && irq_status_clear) |=> st_reg.irq_pending)
        else $error("event lost against clear");

    a_suspend_low: assert property (
        (irq_suspend_select && suspend_idle)
        |=> int_pin_oe_n == `HIC_OE_N_DRIVE)
        else $error("suspend indication not low");

    a_suspend_high: assert property (
        (irq_suspend_select && !suspend_idle)
        |=> int_pin_oe_n == `HIC_OE_N_RELEASE)
        else $error("suspend indication not released");

    // Relations between the registered outputs, and with the filtered select a cycle earlier
    a_hub_switch_split: assert property (
        port3_hub_en != switch_en)
        else $error("hub port and switch both on or both off");

    a_reduced_with_switch: assert property (
        (port12_hiz == switch_en) && (core_low_power == switch_en))
        else $error("ports 1,2 or core power not tied to bypass");

    a_hub_full_power: assert property (
        sif.level |=> (!port12_hiz && !core_low_power))
        else $error("ports 1,2 or core reduced in hub mode");

    a_swap_hub_only: assert property (
        swap_eff |-> port3_hub_en)
        else $error("polarity swap in effect outside hub mode");

    a_drain_level_low: assert property (
        int_pin_out == `HIC_PIN_LOW)
        else $error("open-drain data not low");

    // Interrupt event bookkeeping across both pin meanings
    a_general_no_event: assert property (
        (!irq_suspend_select && !status_update && !st_reg.irq_pending)
        |=> int_pin_oe_n == `HIC_OE_N_RELEASE)
        else $error("general interrupt asserted without event");

    a_set_wins_pin: assert property (
        (!irq_suspend_select && status_update && irq_status_clear)
        |=> int_pin_oe_n == `HIC_OE_N_DRIVE)
        else $error("pin released although an event came");

    a_clear_any_mode: assert property (
        (irq_status_clear && !status_update) |=> !st_reg.irq_pending)
        else $error("event not cleared by status write");

    a_pending_in_suspend: assert property (
        (irq_suspend_select && st_reg.irq_pending && !irq_status_clear)
        |=> st_reg.irq_pending)
        else $error("event dropped while in suspend meaning");

    // A meaning flip must not lose an event the host has not cleared
    a_general_return: assert property (
        ($fell(irq_suspend_select) && st_reg.irq_pending
         && !irq_status_clear)
        |=> int_pin_oe_n == `HIC_OE_N_DRIVE)
        else $error("kept event not shown on return to general");

    c_enter_bypass: cover property (
        port3_hub_en ##1 switch_en);
    c_leave_bypass: cover property (
        switch_en ##1 port3_hub_en);
    c_general_cycle: cover property (
        !irq_suspend_select && status_update ##[1:20]
        int_pin_oe_n == `HIC_OE_N_RELEASE);
    c_suspend_active: cover property (
        irq_suspend_select && hub_configured && !hub_suspended);
    // Wire seen low by the host while the pin is driven
    c_wire_low: cover property (
        !int_pin_oe_n && !int_pin_in);

endmodule : hic_top

// ==== testbench/hic_host_model.sv ====
// Host system model driving bypass select and servicing the interrupt
`timescale 1ns/100ps
module hic_host_model (
    input wire logic bypass_req,
    input wire logic bypass_capable,
    input wire logic clear_req,
    input wire logic int_pin_out,
    input wire logic int_pin_oe_n,
    output logic bypass_n_pin,
    output logic irq_status_clear,
    output logic int_wire
);
    // Parts without bypass keep the select negated high
    assign bypass_n_pin = bypass_capable ? ~bypass_req : 1'h1;
    // Status register write releases the interrupt
    assign irq_status_clear = clear_req;
    // Pull-up on the released open-drain wire
    assign int_wire = int_pin_oe_n ? 1'h1 : int_pin_out;
endmodule : hic_host_model

// ==== testbench/hic_top_test.sv ====
// Self-checking bench for the hub interrupt and bypass control
`timescale 1ns/100ps
module hic_top_test;
    logic clk, rst_n, sel, swap, upd, cfg, susp, byp, cap, clr;
    logic byp_n, clr_pin, int_wire, int_out, int_oe_n;
    logic p3, sw, hiz, lp, swe;
    int errors, n_compared;
    wire logic [4:0] mode_bus = {p3, sw, hiz, lp, swe};
    wire logic [4:0] int_bus = {4'h0, int_wire};

    hic_top u_hic_top (.clk(clk), .rst_n(rst_n), .bypass_n_pin(byp_n),
        .irq_suspend_select(sel), .line_polarity_swap(swap),
        .status_update(upd), .irq_status_clear(clr_pin),
        .hub_configured(cfg), .hub_suspended(susp),
        .int_pin_in(int_wire), .int_pin_out(int_out),
        .int_pin_oe_n(int_oe_n), .port3_hub_en(p3), .switch_en(sw),
        .port12_hiz(hiz), .core_low_power(lp), .swap_eff(swe));
    hic_host_model u_hic_host_model (.bypass_req(byp), .bypass_capable(cap),
        .clear_req(clr), .int_pin_out(int_out), .int_pin_oe_n(int_oe_n),
        .bypass_n_pin(byp_n), .irq_status_clear(clr_pin),
        .int_wire(int_wire));

    // Free-running clock
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task check(input string what, input logic [4:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task stop_test;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    // Hub mode after reset, interrupt released
    task t_reset;
        check("mode", mode_bus, 5'h10);
        check("int", int_bus, 5'h01);
    endtask : t_reset

    // Bypass entry and exit through the synchroniser
    task t_bypass;
        swap = 1'h1;
        cyc(1);
        check("swap", mode_bus, 5'h11);
        byp = 1'h1;
        cyc(4);
        check("byp_early", mode_bus, 5'h11);
        cyc(1);
        check("byp", mode_bus, 5'h0E);
        byp = 1'h0;
        cyc(5);
        check("hub", mode_bus, 5'h11);
        cap = 1'h0;
        byp = 1'h1;
        cyc(6);
        check("no_byp", mode_bus, 5'h11);
        cap = 1'h1;
        byp = 1'h0;
        swap = 1'h0;
        cyc(5);
    endtask : t_bypass

    // General interrupt set, held, set-wins, cleared
    task t_general;
        sel = 1'h0;
        upd = 1'h1;
        cyc(1);
        upd = 1'h0;
        check("int_set", int_bus, 5'h00);
        cyc(20);
        check("int_hold", int_bus, 5'h00);
        clr = 1'h1;
        upd = 1'h1;
        cyc(1);
        upd = 1'h0;
        check("int_both", int_bus, 5'h00);
        cyc(1);
        clr = 1'h0;
        check("int_clr", int_bus, 5'h01);
    endtask : t_general

    // Suspend indication over all hub states
    task t_suspend;
        sel = 1'h1;
        for (int i = 0; i < 4; i++) begin
            {cfg, susp} = 2'(i);
            cyc(1);
            check("susp", int_bus, {4'h0, cfg & ~susp});
        end
        susp = 1'h0;
        upd = 1'h1;
        cyc(1);
        upd = 1'h0;
        check("susp_evt", int_bus, 5'h01);
        sel = 1'h0;
        cyc(1);
        check("gen_kept", int_bus, 5'h00);
        clr = 1'h1;
        cyc(1);
        clr = 1'h0;
        cfg = 1'h0;
        check("gen_back", int_bus, 5'h01);
    endtask : t_suspend

    // Watchdog
    initial begin
        #(2000 * 50);
        errors++;
        stop_test();
    end

    // Main sequence
    initial begin
        {sel, swap, upd, cfg, susp, byp, clr} = 7'h00;
        cap = 1'h1;
        rst_n = 1'h0;
        errors = 0;
        n_compared = 0;
        cyc(2);
        rst_n = 1'h1;
        cyc(1);
        t_reset();
        t_bypass();
        t_general();
        t_suspend();
        stop_test();
    end
endmodule : hic_top_test
